// [bench/tb_thbp_host_bus_port.sv]
// Self-checking bench for the timer host bus port.
`timescale 1ns/100ps
module tb_thbp_host_bus_port;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic wide = 1'b0;
   logic [4:0] gate = 5'h1F;
   logic [15:0] status = 16'h0000;
   logic [15:0] rdw = 16'h0000;
   logic cs_n, rd_n, wr_n, ctrl, wctl, wstb, rstb, por;
   logic [15:0] drv, en, bus, dout, oe, word, q, v;
   logic [4:0] aux;
   int mismatches = 0;
   int samples_checked = 0;
   int wcnt = 0;
   int rcnt = 0;
   int n;
   int m;

   always #2.5 core_clk_i = ~core_clk_i;

   // Undriven lines show the inverse of the host value, never a stale copy.
   assign bus = (oe & dout) | (~oe & en & drv) | (~oe & ~en & ~drv);

   // Completed writes are counted so that lone bytes can be told apart.
   always @(posedge core_clk_i)
   begin
      wcnt += int'(wstb);
      rcnt += int'(rstb);
   end

   thbp_host_model u_host (.clk_i(core_clk_i), .wide_i(wide), .gate_i(gate),
      .bus_i(bus), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .ctrl_o(ctrl),
      .drv_o(drv), .en_o(en));

   thbp_host_bus_port u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .chip_sel_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .ctrl_data_sel_i(ctrl),
      .host_bus_lines_i(bus), .host_bus_lines_o(dout), .host_bus_lines_oe_o(oe),
      .bus_width_bit_i(wide), .status_word_i(status), .data_read_word_i(rdw),
      .write_word_o(word), .write_ctrl_port_o(wctl), .write_strobe_o(wstb),
      .data_read_strobe_o(rstb), .aux_gate_n_o(aux), .por_pending_o(por));

   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog: the whole run needs well under a tenth of this span.
   initial
   begin
      #200000;
      mismatches++;
      test_done();
   end

   // Main sequence: reset, unselected strobes, narrow traffic, wide traffic.
   initial
   begin
      void'($urandom(32'h1007f2a2));
      repeat (3) @(negedge core_clk_i);
      reset_i = 1'b0;
      chk("oe_reset", oe, 16'h0000);
      chk("aux_reset", {11'h000, aux}, 16'h001F);
      chk("por_reset", {15'h0000, por}, 16'h0001);
      u_host.rd_n_o = 1'b0;
      repeat (6) @(negedge core_clk_i);
      chk("oe_no_cs", oe, 16'h0000);
      u_host.rd_n_o = 1'b1;
      u_host.wr_n_o = 1'b0;
      repeat (6) @(negedge core_clk_i);
      u_host.wr_n_o = 1'b1;
      repeat (6) @(negedge core_clk_i);
      chk("wr_no_cs", 16'(wcnt), 16'h0000);
      chk("por_no_cs", {15'h0000, por}, 16'h0001);
      $display("test unselected done");
      for (int i = 0; i < 8; i++)
      begin
         v = 16'($urandom());
         status = 16'($urandom());
         rdw = 16'($urandom());
         gate = (i == 0) ? 5'h00 : 5'($urandom());
         n = wcnt;
         u_host.xfer(1'b1, 1'b1, {8'h00, v[7:0]}, q);
         chk("por_clear", {15'h0000, por}, 16'h0000);
         chk("ctl_word", word, {8'h00, v[7:0]});
         chk("ctl_port", {15'h0000, wctl}, 16'h0001);
         chk("aux_gate", {11'h000, aux}, {11'h000, gate});
         u_host.xfer(1'b1, 1'b0, {8'h00, v[7:0]}, q);
         chk("low_byte_cnt", 16'(wcnt - n), 16'h0001);
         u_host.xfer(1'b1, 1'b0, {8'h00, v[15:8]}, q);
         chk("dat_cnt", 16'(wcnt - n), 16'h0002);
         chk("dat_word", word, v);
         chk("dat_port", {15'h0000, wctl}, 16'h0000);
         m = rcnt;
         u_host.xfer(1'b0, 1'b1, 16'h0000, q);
         chk("rd_status", q, {3'h7, gate, status[7:0]});
         u_host.xfer(1'b0, 1'b0, 16'h0000, q);
         chk("rd_low", q, {3'h7, gate, rdw[7:0]});
         chk("rd_stb_low", 16'(rcnt - m), 16'h0000);
         u_host.xfer(1'b0, 1'b0, 16'h0000, q);
         chk("rd_high", q, {3'h7, gate, rdw[15:8]});
         chk("rd_stb_pair", 16'(rcnt - m), 16'h0001);
         chk("oe_idle", oe, 16'h0000);
      end
      $display("test narrow done");
      wide = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 16'hFFFF : 16'($urandom());
         rdw = (i == 0) ? 16'h0000 : 16'($urandom());
         u_host.xfer(1'b1, 1'b0, v, q);
         chk("wide_word", word, v);
         m = rcnt;
         u_host.xfer(1'b0, 1'b0, 16'h0000, q);
         chk("wide_read", q, rdw);
         chk("wide_rd_stb", 16'(rcnt - m), 16'h0001);
         chk("wide_aux", {11'h000, aux}, 16'h001F);
      end
      $display("test wide done");
      test_done();
   end
endmodule // tb_thbp_host_bus_port

// [bench/thbp_host_model.sv]
// Host processor model that drives the strobes and the shared bus lines.
`timescale 1ns/100ps
module thbp_host_model
(
   input wire logic clk_i,
   input wire logic wide_i,
   input wire logic [4:0] gate_i,
   input wire logic [15:0] bus_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic ctrl_o,
   output logic [15:0] drv_o,
   output logic [15:0] en_o
);
   logic [15:0] wd;
   logic wen;

   // In narrow mode the upper lines carry the gates and stay high above them.
   assign drv_o = wide_i ? wd : {3'h7, gate_i, wd[7:0]};
   assign en_o = wide_i ? {16{wen}} : {8'hFF, {8{wen}}};

   // Idle host: nothing selected, no data driven.
   initial
   begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      ctrl_o = 1'b0;
      wd = 16'h0000;
      wen = 1'b0;
   end

   // One strobe, held six cycles low and five high; only one strobe is ever low.
   task automatic xfer(input logic w, input logic c, input logic [15:0] d,
      output logic [15:0] q);
      @(negedge clk_i);
      cs_n_o = 1'b0;
      ctrl_o = c;
      wd = d;
      wen = w;
      wr_n_o = ~w;
      rd_n_o = w;
      repeat (6) @(negedge clk_i);
      q = bus_i;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      repeat (5) @(negedge clk_i);
      cs_n_o = 1'b1; // Never tied low, so no software reset is needed.
      wen = 1'b0;
   endtask
endmodule // thbp_host_model

// [verilog/thbp_host_bus_port.sv]
// Host parallel bus port of the five-counter timing controller.
`timescale 1ns/100ps
module thbp_host_bus_port
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic chip_sel_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic ctrl_data_sel_i,
   input wire logic [15:0] host_bus_lines_i,
   output logic [15:0] host_bus_lines_o,
   output logic [15:0] host_bus_lines_oe_o,
   input wire logic bus_width_bit_i,
   input wire logic [15:0] status_word_i,
   input wire logic [15:0] data_read_word_i,
   output logic [15:0] write_word_o,
   output logic write_ctrl_port_o,
   output logic write_strobe_o,
   output logic data_read_strobe_o,
   output logic [4:0] aux_gate_n_o,
   output logic por_pending_o
);

   // Host pins are asynchronous to core_clk_i. Every strobe, the port select and the bus
   // lines pass two flops, and a third copy of the strobes gives clean edges. A transfer
   // therefore lands about three cycles after the host moves a strobe. The host must keep
   // each strobe level for at least four cycles, or an edge can be missed. The output
   // enable is the one path that looks at the live pins, so that the lines float as soon
   // as the host lets go.
   // Whole module state in one record.
   typedef struct packed {
      logic [3:0] meta;
      thbp_pkg::thbp_pins_s pins;
      thbp_pkg::thbp_pins_s prev;
      logic [15:0] gate_meta;
      logic [15:0] bus_in;
      logic [4:0] aux;
      logic [15:0] rd_data;
      logic rd_active;
      logic rd_hi_byte;
      logic wr_hi_byte;
      logic [7:0] wr_low;
      logic [15:0] wr_data;
      logic wr_ctrl;
      logic wr_pulse;
      logic rd_pulse;
      logic por;
   } thbp_state_s;

   thbp_state_s st;
   thbp_state_s next_st;
   logic wide;
   logic wr_release;
   logic rd_begin;
   logic rd_finish;

   // Width is taken straight from the master configuration bit; reset of that bit lives
   // outside, so after reset the port is narrow.
   assign wide = bus_width_bit_i;

   // Edges compare the second synchroniser stage with a third copy, so nothing but the
   // second stage ever reads the first. This costs one cycle of latency per strobe, which
   // the host absorbs through its minimum strobe width.
   assign wr_release = st.prev.wr_n == 1'b0 && st.pins.wr_n == 1'b1 &&
                       st.prev.cs_n == 1'b0;
   assign rd_begin = st.prev.rd_n == 1'b1 && st.pins.rd_n == 1'b0 &&
                     st.pins.cs_n == 1'b0;
   // A read ends when either the strobe or the chip select lets go.
   assign rd_finish = st.rd_active && (st.pins.rd_n == 1'b1 || st.pins.cs_n == 1'b1);

   // Next-state logic for synchronisers, byte pairing and transfers.
   always_comb
   begin
      next_st = st;
      next_st.wr_pulse = 1'b0;
      next_st.rd_pulse = 1'b0;
      // Two-flop synchronisers on all host pins.
      next_st.meta = {chip_sel_n_i, rd_n_i, wr_n_i, ctrl_data_sel_i};
      next_st.pins = st.meta;
      next_st.prev = st.pins;
      next_st.gate_meta = host_bus_lines_i;
      next_st.bus_in = st.gate_meta;
      // Auxiliary gates sampled only in narrow mode; ones otherwise.
      next_st.aux = wide ? 5'h1F : st.bus_in[thbp_pkg::GATE_LSB +: thbp_pkg::GATE_N];
      // First chip select seen clears the power-on condition.
      if (st.pins.cs_n == 1'b0)
      begin
         next_st.por = 1'b0;
      end
      // Capture bus data while write and chip select are both low.
      if (st.pins.cs_n == 1'b0 && st.pins.wr_n == 1'b0)
      begin
         next_st.wr_ctrl = st.pins.ctrl;
         if (wide)
         begin
            next_st.wr_data = st.bus_in;
         end
         else if (st.pins.ctrl || !st.wr_hi_byte)
         begin
            next_st.wr_data = {8'h00, st.bus_in[7:0]};
         end
         else
         begin
            next_st.wr_data = {st.bus_in[7:0], st.wr_low};
         end
      end
      // Completion at write release; narrow data words pair low then high byte.
      if (wr_release)
      begin
         if (!wide && !st.wr_ctrl)
         begin
            if (!st.wr_hi_byte)
            begin
               next_st.wr_low = st.wr_data[7:0];
               next_st.wr_hi_byte = 1'b1;
            end
            else
            begin
               next_st.wr_hi_byte = 1'b0;
               next_st.wr_pulse = 1'b1;
            end
         end
         else
         begin
            next_st.wr_hi_byte = 1'b0;
            next_st.wr_pulse = 1'b1;
         end
      end
      // Read start latches source; read release advances byte order.
      if (rd_begin)
      begin
         next_st.rd_active = 1'b1;
         if (st.pins.ctrl)
         begin
            next_st.rd_data = status_word_i;
         end
         else if (!st.rd_hi_byte || wide)
         begin
            next_st.rd_data = data_read_word_i;
         end
      end
      if (rd_finish)
      begin
         next_st.rd_active = 1'b0;
         if (!wide && !st.pins.ctrl)
         begin
            next_st.rd_hi_byte = !st.rd_hi_byte;
            next_st.rd_pulse = st.rd_hi_byte;
         end
         else
         begin
            next_st.rd_pulse = !st.pins.ctrl;
         end
      end
      // A control write restarts byte pairing.
      if (next_st.wr_pulse && st.wr_ctrl)
      begin
         next_st.rd_hi_byte = 1'b0;
      end
   end

   // Register the state; everything restarts idle with gates off and the power-on condition set.
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         st <= '0;
         st.meta <= 4'hF;
         st.pins <= 4'hF;
         st.prev <= 4'hF;
         st.gate_meta <= thbp_pkg::ALL_OE;
         st.bus_in <= thbp_pkg::ALL_OE;
         st.aux <= 5'h1F;
         st.por <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Drive only while chip select and read are both low, live pins gate the enable so
   // the bus floats as soon as the host lets go.
   always_comb
   begin
      host_bus_lines_oe_o = thbp_pkg::WORD_ZERO;
      if (!chip_sel_n_i && !rd_n_i && wr_n_i)
      begin
         host_bus_lines_oe_o = wide ? thbp_pkg::ALL_OE : thbp_pkg::LOW_OE;
      end
   end

   // Narrow mode presents the low then high byte of each data word.
   assign host_bus_lines_o = wide ? st.rd_data :
      {thbp_pkg::BYTE_ZERO, (st.rd_hi_byte && !st.pins.ctrl) ? st.rd_data[15:8] :
      st.rd_data[7:0]};
   assign write_word_o = st.wr_data;
   assign write_ctrl_port_o = st.wr_ctrl;
   assign write_strobe_o = st.wr_pulse;
   assign data_read_strobe_o = st.rd_pulse;
   assign aux_gate_n_o = st.aux;
   assign por_pending_o = st.por;

   // Width command is an 8-bit write with lines 13-15 high.
   AST_WIDTH_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (write_strobe_o && !wide && write_ctrl_port_o) |-> write_word_o[15:8] == 8'h00)
      else $error("narrow control write carried high byte");
   AST_FLOAT: assert property (@(posedge core_clk_i) disable iff (reset_i)
      chip_sel_n_i |-> host_bus_lines_oe_o == 16'h0000)
      else $error("bus driven without chip select");
   AST_NARROW_OE: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !wide |-> host_bus_lines_oe_o[15:8] == 8'h00)
      else $error("upper lines driven in narrow mode");
   AST_DRIVE: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (!chip_sel_n_i && !rd_n_i && wr_n_i) |-> host_bus_lines_oe_o[7:0] == 8'hFF)
      else $error("read not driving bus");
   AST_POR: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !st.pins.cs_n |=> !por_pending_o)
      else $error("power-on condition not cleared");
   AST_PULSE: assert property (@(posedge core_clk_i) disable iff (reset_i)
      write_strobe_o |=> !write_strobe_o)
      else $error("write strobe longer than one cycle");
   AST_AUX: assert property (@(posedge core_clk_i) disable iff (reset_i)
      wide |=> aux_gate_n_o == 5'h1F)
      else $error("aux gates active in wide mode");
   AST_NO_WR_IDLE: assert property (@(posedge core_clk_i) disable iff (reset_i)
      $rose(write_strobe_o) |-> $past(st.pins.cs_n, 2) == 1'b0)
      else $error("write completed without chip select");

   // A write as the synchronised pins see it: strobe and select held low together.
   sequence seq_wr_held;
      st.pins.cs_n == 1'b0 && st.pins.wr_n == 1'b0;
   endsequence

   // Release of a write that finishes a transfer: wide, control, or the high byte.
   sequence seq_wr_final;
      st.pins.wr_n == 1'b1 && (wide || st.wr_ctrl || st.wr_hi_byte);
   endsequence

   // Release of the first byte of a narrow data word, which must only be remembered.
   sequence seq_wr_first;
      st.pins.wr_n == 1'b1 && !wide && !st.wr_ctrl && !st.wr_hi_byte;
   endsequence

   // A finished write raises the strobe in the cycle after the release is seen.
   AST_WR_DONE: assert property (@(posedge core_clk_i) disable iff (reset_i)
      seq_wr_held ##1 seq_wr_final |=> write_strobe_o)
      else $error("finished write gave no strobe");

   // A lone low byte is kept back until its high byte arrives.
   AST_LOW_BYTE: assert property (@(posedge core_clk_i) disable iff (reset_i)
      seq_wr_held ##1 seq_wr_first |=> !write_strobe_o && st.wr_hi_byte)
      else $error("low byte not held for pairing");

   // A control read latches the status word when the strobe falls.
   AST_RD_STATUS: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (rd_begin && st.pins.ctrl) |=> st.rd_data == $past(status_word_i))
      else $error("control read did not latch status");

   // A data read latches the addressed word, except for the second byte of a narrow pair.
   AST_RD_WORD: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (rd_begin && !st.pins.ctrl && (wide || !st.rd_hi_byte))
      |=> st.rd_data == $past(data_read_word_i))
      else $error("data read did not latch addressed word");

   // In wide mode a read drives every line.
   AST_WIDE_OE: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (!chip_sel_n_i && !rd_n_i && wr_n_i && wide) |-> host_bus_lines_oe_o == 16'hFFFF)
      else $error("wide read not driving all lines");

   // While the host writes, the port never fights it on the lines.
   AST_WR_QUIET: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !wr_n_i |-> host_bus_lines_oe_o == 16'h0000)
      else $error("bus driven during a write");

   // The data read strobe lasts one cycle, so the pointer advances once.
   AST_RD_PULSE: assert property (@(posedge core_clk_i) disable iff (reset_i)
      data_read_strobe_o |=> !data_read_strobe_o)
      else $error("read strobe longer than one cycle");

   // Control reads never advance the data pointer.
   AST_CTRL_RD: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (rd_finish && st.pins.ctrl) |=> !data_read_strobe_o)
      else $error("control read advanced the pointer");

   // The power-on condition stays until a chip select is seen.
   AST_POR_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (por_pending_o && st.pins.cs_n) |=> por_pending_o)
      else $error("power-on condition lost without chip select");

   // In narrow mode the auxiliary gates follow the synchronised upper lines.
   AST_AUX_NARROW: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !wide |=> aux_gate_n_o == $past(st.bus_in[12:8]))
      else $error("aux gates do not follow lines");

   // A control write always leaves byte pairing at the low byte.
   AST_CTRL_PAIR: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (write_strobe_o && write_ctrl_port_o) |-> !st.wr_hi_byte)
      else $error("control write left pairing open");

   // Strobes seen without chip select never complete a write.
   AST_IGNORED: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (st.pins.cs_n && st.prev.cs_n) |=> !write_strobe_o)
      else $error("write completed while unselected");

   // Narrow reads leave the upper data byte at zero as well as undriven.
   AST_NARROW_DATA: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (!wide && !chip_sel_n_i && !rd_n_i) |-> host_bus_lines_o[15:8] == 8'h00)
      else $error("upper byte carries data in narrow mode");

endmodule // thbp_host_bus_port

// [verilog/thbp_pkg.sv]
// Package of constants and carrier types for the timer host bus port.
package thbp_pkg;
   localparam int unsigned BUS_W = 16;
   localparam int unsigned LOW_W = 8;
   localparam int unsigned GATE_N = 5;
   localparam int unsigned GATE_LSB = 8;
   localparam int unsigned HOLD_LSB = 13;
   localparam logic [2:0] HOLD_HIGH = 3'h7;
   localparam logic [1:0] SYNC_RESET = 2'h3;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [BUS_W-1:0] LOW_OE = 16'h00FF;
   localparam logic [BUS_W-1:0] ALL_OE = 16'hFFFF;

   // Internal-side write request that goes to the register file.
   typedef struct packed {
      logic valid;
      logic ctrl_port;
      logic [15:0] data;
   } thbp_wreq_s;

   // Synchronised host strobes and port select.
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic ctrl;
   } thbp_pins_s;
endpackage
